/* src/cia_pkg.sv */
package cia_pkg;

    // ==========================================================
    // geometry
    localparam int NUM_IN       = 8;
    localparam int NUM_CH       = 8;
    localparam int CFG_W        = 16;
    localparam int NAME_W       = 16;

    // ==========================================================
    // timing
    localparam longint CLK_HZ       = 50000000;
    localparam int     HOLD_MS      = 1000;
    localparam int     HOLD_CYCLES  = int'((CLK_HZ * HOLD_MS + 999) / 1000);

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_ACTION   = 8'h00;
    localparam logic [7:0] OFF_MODE     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_TIME     = 8'h0c;
    localparam logic [7:0] OFF_BATCH    = 8'h10;
    localparam logic [7:0] OFF_SELECT   = 8'h14;
    localparam logic [7:0] OFF_IFACE    = 8'h18;
    localparam logic [7:0] OFF_COPY     = 8'h1c;
    localparam logic [7:0] OFF_CHCFG    = 8'h20;
    localparam logic [7:0] OFF_CHNAME   = 8'h24;
    localparam logic [7:0] OFF_IFDATA   = 8'h28;
    localparam logic [7:0] OFF_CNT      = 8'h2c;

    // ==========================================================
    // mode register fields
    localparam int MODE_PSPEC_BIT  = 0;
    localparam int MODE_LED_LSB    = 1;
    localparam int MODE_AUTOB_BIT  = 3;
    localparam int MODE_FBUS_BIT   = 4;
    localparam int MODE_CHSEL_LSB  = 8;

    // ==========================================================
    // reset values, response codes and counter limits
    localparam logic [31:0] ACTION_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] IFACE_RST  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK    = 2'h0;
    localparam logic [1:0]  RESP_ERR   = 2'h2;
    localparam logic [5:0]  SEC_MAX    = 6'h3b;
    localparam logic [5:0]  SEC_HALF   = 6'h1e;
    localparam logic [23:0] BATCH_MAX  = 24'h999999;

    // ==========================================================
    // per-input action codes, 4 bits each
    typedef enum logic [3:0] {
        ACT_RECORD, ACT_TSYNC, ACT_PRODUCT, ACT_PSEL, ACT_STXT, ACT_TSEL, ACT_CURVE,
        ACT_BRST, ACT_GREEN, ACT_RED, ACT_HGLR, ACT_LGHR, ACT_LIMITS
    } cia_action_t;

    // led mode field
    typedef enum logic [1:0] {
        LED_INTERNAL, LED_ONE_INPUT, LED_TWO_INPUT
    } cia_led_t;

    // data interface per-input codes, 2 bits each
    typedef enum logic [1:0] {
        IF_RECV, IF_SEND_STATUS, IF_SEND_TOTAL, IF_SEND_BOTH
    } cia_iface_t;

endpackage

/* src/cia_dispatch.sv */
// What this block does
// - inputs active high, trigger on active
// - sync edge clears seconds counter
// - seconds 30..59 add one minute
// - product run enables product limit monitoring
// - product index from weighted select inputs
// - store-text edge saves selected text
// - text index from binary select inputs
// - curve input gates channel recording
// - limit monitoring ignores curve input
// - auto batch number increments per start
// - batch clear after one second hold
// - two-input mode: green, red inputs
// - high-green polarity drives leds
// - low-green polarity drives leds
// - led actions need matching led mode
// - limits-active input gates monitoring
// - fieldbus exchange only when module enabled, except writes to OFF_CNT
// - copy config, stamp channel number
`timescale 1ns/10ps
`default_nettype none

module cia_dispatch
    import cia_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES
) (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // external control inputs
    input  wire logic [NUM_IN-1:0]  control_input_line,
    // front leds
    output logic                    led_green,
    output logic                    led_red,
    // recorder control
    output logic                    limit_monitor_en,
    output logic                    product_limits_en,
    output logic                    curve_record_en,
    output logic                    text_store_pulse,
    output logic [3:0]              stored_text_index
);

    // ==========================================================
    // input synchroniser and edge detect
    logic [NUM_IN-1:0] sync1_reg, sync1_next;
    logic [NUM_IN-1:0] sync2_reg, sync2_next;
    logic [NUM_IN-1:0] prev_reg, prev_next;
    logic [NUM_IN-1:0] rise;

    always_comb begin
        sync1_next = control_input_line;
        sync2_next = sync1_reg;
        prev_next  = sync2_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg  <= prev_next;
        end
    end

    assign rise = sync2_reg & ~prev_reg;

    // ==========================================================
    // registers
    logic [31:0] action_reg, action_next;
    logic [31:0] mode_reg, mode_next;
    logic [15:0] iface_reg, iface_next;
    logic [5:0]  sec_reg, sec_next;
    logic [15:0] min_reg, min_next;
    logic [23:0] batch_reg, batch_next;
    logic        bstart_req;
    logic        time_wr;
    logic [31:0] wdata_reg;
    logic [31:0] ifdata_reg, ifdata_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [CFG_W-1:0]  chcfg_reg [NUM_CH];
    logic [NAME_W-1:0] chname_reg [NUM_CH];
    logic [2:0]  copy_dst;
    logic        copy_go;

    // per-input decode
    logic [NUM_IN-1:0] is_act [16];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_dec
            for (genvar ga = 0; ga < 16; ga++) begin : g_act
                assign is_act[ga][gi] = (action_reg[gi*4 +: 4] == 4'(ga));
            end
        end
    endgenerate

    cia_led_t led_mode;
    assign led_mode = cia_led_t'(mode_reg[MODE_LED_LSB +: 2]);

    // weighted bcd from lowest free inputs
    function automatic logic [3:0] bcd(input logic [NUM_IN-1:0] sel,
                                       input logic [NUM_IN-1:0] lvl);
        logic [3:0] v;
        int         w;
        v = '0;
        w = 0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (sel[i] && w < 4) begin
                v[w] = lvl[i];
                w    = w + 1;
            end
        end
        return v;
    endfunction

    // ==========================================================
    // time, batch and hold counter
    logic [31:0] hold_reg, hold_next;
    logic        hold_done_reg, hold_done_next;
    logic [31:0] tick_reg, tick_next;
    logic        sec_tick;

    // one second prescaler for the clock
    assign sec_tick = (tick_reg == 32'(HOLD_COUNT - 1));

    always_comb begin
        tick_next      = sec_tick ? '0 : tick_reg + 32'h1;
        sec_next       = !sec_tick ? sec_reg : (sec_reg == SEC_MAX) ? '0 : sec_reg + 6'h01;
        min_next       = (sec_tick && sec_reg == SEC_MAX) ? min_reg + 16'h0001 : min_reg;
        // software sets the time, second restarts
        if (time_wr) begin
            tick_next = '0;
            sec_next  = wdata_reg[5:0];
            min_next  = wdata_reg[21:6];
        end
        hold_next      = hold_reg;
        hold_done_next = hold_done_reg;
        batch_next     = batch_reg;
        if (|(rise & is_act[ACT_TSYNC])) begin
            sec_next = '0;
            tick_next = '0;
            min_next = (sec_reg >= SEC_HALF) ? min_reg + 16'h0001 : min_reg;
        end
        if (mode_reg[MODE_AUTOB_BIT] && (bstart_req || |(rise & is_act[ACT_PRODUCT])))
            batch_next = (batch_reg == BATCH_MAX) ? '0 : batch_reg + 24'h000001;
        if (|(sync2_reg & is_act[ACT_BRST])) begin
            if (hold_reg < 32'(HOLD_COUNT - 1)) begin
                hold_next = hold_reg + 32'h1;
            end else if (!hold_done_reg) begin
                hold_done_next = 1'b1;
                batch_next     = '0;
            end
        end else begin
            hold_next      = '0;
            hold_done_next = 1'b0;
        end
    end

    // ==========================================================
    // outputs
    logic       green_next, red_next;
    logic       lim_next, plim_next, curve_next, tstore_next;
    logic [3:0] tidx_next;
    logic       has_lim;

    always_comb begin
        green_next = 1'b0;
        red_next   = 1'b0;
        unique case (led_mode)
            LED_TWO_INPUT: begin
                green_next = |(sync2_reg & is_act[ACT_GREEN]);
                red_next   = |(sync2_reg & is_act[ACT_RED]);
            end
            LED_ONE_INPUT: begin
                if (|is_act[ACT_HGLR]) begin
                    green_next = |(sync2_reg & is_act[ACT_HGLR]);
                    red_next   = ~green_next;
                end else if (|is_act[ACT_LGHR]) begin
                    red_next   = |(sync2_reg & is_act[ACT_LGHR]);
                    green_next = ~red_next;
                end
            end
            default: begin
                green_next = 1'b1;
            end
        endcase
        // monitor unless gated by limits input
        has_lim  = |is_act[ACT_LIMITS];
        lim_next = has_lim ? |(sync2_reg & is_act[ACT_LIMITS]) : 1'b1;
        plim_next = mode_reg[MODE_PSPEC_BIT] & |(sync2_reg & is_act[ACT_PRODUCT]);
        curve_next = |is_act[ACT_CURVE] ? |(sync2_reg & is_act[ACT_CURVE]) : 1'b1;
        tstore_next = |(rise & is_act[ACT_STXT]);
        tidx_next   = tstore_next ? bcd(is_act[ACT_TSEL], sync2_reg) : stored_text_index;
    end

    // ==========================================================
    // axi4-lite slave
    logic [7:0]  awaddr_reg;
    logic        aw_have, w_have;
    logic        do_wr;
    logic [31:0] rd_val;
    logic        rd_ok, wr_ok;

    assign do_wr   = aw_have && w_have && !s_axi_bvalid;
    assign copy_dst = wdata_reg[2:0];
    assign copy_go  = do_wr && (awaddr_reg == OFF_COPY);
    assign bstart_req = do_wr && (awaddr_reg == OFF_STATUS) && wdata_reg[0];
    assign time_wr = do_wr && (awaddr_reg == OFF_TIME);
    assign wr_ok = awaddr_reg <= OFF_CNT;

    // register writes and interface data
    always_comb begin
        action_next = action_reg;
        mode_next   = mode_reg;
        iface_next  = iface_reg;
        ifdata_next = ifdata_reg;
        cnt_next    = cnt_reg;
        if (do_wr) begin
            unique case (awaddr_reg)
                OFF_ACTION: action_next = wdata_reg;
                OFF_MODE:   mode_next   = wdata_reg;
                OFF_IFACE:  iface_next  = wdata_reg[15:0];
                OFF_CNT:    cnt_next    = wdata_reg;
                OFF_IFDATA: if (mode_reg[MODE_FBUS_BIT]) ifdata_next = wdata_reg;
                default: ;
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = '0;
        unique case (s_axi_araddr)
            OFF_ACTION: rd_val = action_reg;
            OFF_MODE:   rd_val = mode_reg;
            OFF_STATUS: rd_val = {16'h0, 8'(sync2_reg), 3'h0, curve_record_en,
                                  product_limits_en, limit_monitor_en, led_red, led_green};
            OFF_TIME:   rd_val = {10'h0, min_reg, sec_reg};
            OFF_BATCH:  rd_val = {8'h0, batch_reg};
            OFF_SELECT: rd_val = {24'h0, bcd(is_act[ACT_TSEL], sync2_reg),
                                  bcd(is_act[ACT_PSEL], sync2_reg)};
            OFF_IFACE:  rd_val = {16'h0, iface_reg};
            OFF_IFDATA: begin
                for (int i = 0; i < NUM_IN; i++) begin
                    if (mode_reg[MODE_FBUS_BIT]) begin
                        unique case (cia_iface_t'(iface_reg[i*2 +: 2]))
                            IF_RECV:        rd_val[i] = ifdata_reg[i];
                            IF_SEND_STATUS: rd_val[i] = sync2_reg[i];
                            IF_SEND_TOTAL:  rd_val[i] = 1'b0;
                            IF_SEND_BOTH:   rd_val[i] = sync2_reg[i];
                        endcase
                    end
                end
            end
            OFF_CNT:    rd_val = mode_reg[MODE_FBUS_BIT] ? cnt_reg : '0;
            OFF_CHCFG:  rd_val = {16'h0, chcfg_reg[mode_reg[MODE_CHSEL_LSB +: 3]]};
            OFF_CHNAME: rd_val = {16'h0, chname_reg[mode_reg[MODE_CHSEL_LSB +: 3]]};
            default:    rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action_reg <= ACTION_RST;
            mode_reg   <= MODE_RST;
            iface_reg  <= IFACE_RST[15:0];
            ifdata_reg <= '0;
            cnt_reg    <= '0;
            sec_reg    <= '0;
            min_reg    <= '0;
            batch_reg  <= '0;
            hold_reg   <= '0;
            hold_done_reg <= 1'b0;
            tick_reg   <= '0;
            led_green  <= 1'b0;
            led_red    <= 1'b0;
            limit_monitor_en  <= 1'b0;
            product_limits_en <= 1'b0;
            curve_record_en   <= 1'b0;
            text_store_pulse  <= 1'b0;
            stored_text_index <= '0;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OK;
            s_axi_rdata   <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                chcfg_reg[c]  <= '0;
                chname_reg[c] <= '0;
            end
        end else begin
            action_reg <= action_next;
            mode_reg   <= mode_next;
            iface_reg  <= iface_next;
            ifdata_reg <= ifdata_next;
            cnt_reg    <= cnt_next;
            sec_reg    <= sec_next;
            min_reg    <= min_next;
            batch_reg  <= batch_next;
            hold_reg   <= hold_next;
            hold_done_reg <= hold_done_next;
            tick_reg   <= tick_next;
            led_green  <= green_next;
            led_red    <= red_next;
            limit_monitor_en  <= lim_next;
            product_limits_en <= plim_next;
            curve_record_en   <= curve_next;
            text_store_pulse  <= tstore_next;
            stored_text_index <= tidx_next;
            // write channel capture
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have    <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have    <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
                if (awaddr_reg == OFF_CHCFG)
                    chcfg_reg[mode_reg[MODE_CHSEL_LSB +: 3]] <= wdata_reg[CFG_W-1:0];
                if (awaddr_reg == OFF_CHNAME)
                    chname_reg[mode_reg[MODE_CHSEL_LSB +: 3]] <= wdata_reg[NAME_W-1:0];
                if (copy_go) begin
                    chcfg_reg[copy_dst]  <= chcfg_reg[mode_reg[MODE_CHSEL_LSB +: 3]];
                    chname_reg[copy_dst] <= {8'h30, 8'h31 + {5'h0, copy_dst}};
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // read channel
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // cia_dispatch

`default_nettype wire

/* testbench/cia_dispatch_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checker for the dispatch block
module cia_dispatch_asserts
    import cia_pkg::*;
(
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // bus handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // control side
    input wire logic [NUM_IN-1:0] control_input_line,
    input wire logic              text_store_pulse,
    input wire logic [3:0]        stored_text_index
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // text store pulse and captured index
    a_store_one_cycle: assert property (
        text_store_pulse |=> !text_store_pulse) else $error("store pulse too long");
    a_text_idx_held: assert property (
        $changed(stored_text_index) |-> text_store_pulse) else $error("index moved alone");
    a_store_needs_high: assert property (
        text_store_pulse |-> $past(control_input_line, 2) != '0) else $error("store with no input");
    // register bus answers
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_write_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    a_read_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready ##1 !(s_axi_arready && $past(s_axi_arready)))
        else $error("read taken while busy");

    // main scenarios seen
    c_store: cover property (text_store_pulse);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_ERR);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // cia_dispatch_asserts

bind cia_dispatch cia_dispatch_asserts cia_dispatch_asserts_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .control_input_line,
    .text_store_pulse, .stored_text_index
);
`default_nettype wire

/* testbench/cia_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// remote switches and master clock contact
module cia_switch_model
    import cia_pkg::*;
(
    input wire logic              aclk,
    output var logic [NUM_IN-1:0] control_input_line
);
    // all contacts open at power up
    initial control_input_line = '0;

    task automatic put(input logic [7:0] m, input logic [7:0] v, input int lag = 0);
        repeat (lag) @(posedge aclk);
        @(posedge aclk);
        control_input_line <= (control_input_line & ~m) | (v & m);
    endtask

    task automatic hold(input int i, input int n);
        put(8'h01 << i, 8'hff, 1);
        repeat (n) @(posedge aclk);
        put(8'h01 << i, 8'h00);
    endtask
endmodule // cia_switch_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
// ==========================================
// bench for the control input dispatcher
module tb_top
    import cia_pkg::*;
;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rd, a;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
    logic [NUM_IN-1:0] control_input_line;
    logic              led_green, led_red, limit_monitor_en, product_limits_en;
    logic              curve_record_en, text_store_pulse, b;
    logic [3:0]        stored_text_index;
    logic [7:0]        v;
    logic [15:0]       mn;
    int                fail_count = 0, check_count = 0, m_batch = 0, i, k, n;
    int                secs[$] = '{0, 29, 30, 59};

    // 50 MHz clock
    always #10 aclk = ~aclk;

    cia_dispatch #(.HOLD_COUNT(20)) cia_dispatch_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .control_input_line, .led_green,
        .led_red, .limit_monitor_en, .product_limits_en, .curve_record_en,
        .text_store_pulse, .stored_text_index
    );
    cia_switch_model sw (.aclk, .control_input_line);

    // ==========================================
    // bus tasks, each channel held until taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] ad);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge aclk);
    endtask

    // action code of one input in the action word
    function automatic logic [31:0] act(input int idx, input int c);
        return 32'(c) << (4 * idx);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        k = $urandom(6);
        wt(5);
        aresetn <= 1'b1;
        rdr(OFF_MODE); `CHK("mode", MODE_RST, rd)
        rdr(OFF_ACTION); `CHK("action", ACTION_RST, rd)
        rdr(8'h3c); `CHK("rresp", RESP_ERR, rs)
        wr(8'h3c, 32'h1); `CHK("bresp", RESP_ERR, rs)
        // led actions idle in internal mode
        wr(OFF_ACTION, act(0, ACT_GREEN) | act(1, ACT_RED));
        sw.put(8'h03, 8'h02); wt(6);
        `CHK("green", 1'b1, led_green)
        `CHK("red", 1'b0, led_red)
        // one-input led mode, both polarities
        wr(OFF_MODE, 32'h2);
        for (i = 0; i < 8; i++) begin
            wr(OFF_ACTION, act(0, (i < 4) ? ACT_HGLR : ACT_LGHR));
            v = 8'($urandom());
            sw.put(8'h01, v, i % 3); wt(6);
            b = v[0] ^ (i >= 4);
            `CHK("green", b, led_green)
            `CHK("red", ~b, led_red)
        end
        // two-input led mode
        wr(OFF_MODE, 32'h4);
        wr(OFF_ACTION, act(0, ACT_GREEN) | act(1, ACT_RED));
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom()); sw.put(8'h03, v); wt(6);
            `CHK("green", v[0], led_green)
            `CHK("red", v[1], led_red)
        end
        // limits, curve and product gates
        wr(OFF_MODE, 32'h1);
        wr(OFF_ACTION, act(0, ACT_LIMITS) | act(1, ACT_CURVE) | act(2, ACT_PRODUCT));
        for (i = 0; i < 8; i++) begin
            v = 8'($urandom()); sw.put(8'h07, v); wt(6);
            `CHK("limits", v[0], limit_monitor_en)
            `CHK("curve", v[1], curve_record_en)
            `CHK("product", v[2], product_limits_en)
        end
        sw.put(8'h07, 8'h00);
        // binary product and text selection, then text store
        for (k = 0; k < 2; k++) begin
            a = act(0, ACT_STXT);
            for (i = 4; i < 8; i++) a |= act(i, k ? ACT_TSEL : ACT_PSEL);
            wr(OFF_ACTION, a);
            for (i = 0; i < 3; i++) begin
                v = 8'($urandom()); sw.put(8'hf0, v); wt(6);
                rdr(OFF_SELECT); `CHK("select", v[7:4], k ? rd[7:4] : rd[3:0])
            end
        end
        sw.put(8'h01, 8'h01);
        n = 0;
        while (text_store_pulse !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        `CHK("pulse", 1'b1, text_store_pulse)
        `CHK("stored", v[7:4], stored_text_index)
        sw.put(8'hff, 8'h00);
        // time sync rounding at the half minute
        wr(OFF_ACTION, act(2, ACT_TSYNC));
        foreach (secs[i]) begin
            mn = 16'($urandom() % 32'hfff0);
            wr(OFF_TIME, {10'h0, mn, 6'(secs[i])});
            sw.put(8'h04, 8'h04); wt(6);
            rdr(OFF_TIME); `CHK("time", {10'h0, mn + 16'(secs[i] >= 30), 6'h0}, rd)
            sw.put(8'h04, 8'h00); wt(5);
        end
        // auto batch numbering and held reset
        wr(OFF_MODE, 32'h8);
        wr(OFF_ACTION, act(3, ACT_BRST));
        repeat (2 + $urandom() % 4) begin
            wr(OFF_STATUS, 32'h1);
            m_batch++;
        end
        rdr(OFF_BATCH); `CHK("batch", 24'(m_batch), rd[23:0])
        sw.hold(3, 12); wt(6);
        rdr(OFF_BATCH); `CHK("batch", 24'(m_batch), rd[23:0])
        sw.hold(3, 30); wt(6);
        m_batch = 0;
        rdr(OFF_BATCH); `CHK("batch", 24'(m_batch), rd[23:0])
        // copy channel settings
        mn = 16'($urandom());
        wr(OFF_MODE, 32'h100);
        wr(OFF_CHCFG, {16'h0, mn});
        wr(OFF_CHNAME, 32'h4142);
        wr(OFF_COPY, 32'h3);
        wr(OFF_MODE, 32'h300);
        rdr(OFF_CHCFG); `CHK("cfg", mn, rd[15:0])
        rdr(OFF_CHNAME); `CHK("name", 16'h3034, rd[15:0])
        // fieldbus data idle while module disabled
        wr(OFF_MODE, 32'h0);
        wr(OFF_IFDATA, 32'hff);
        rdr(OFF_IFDATA); `CHK("ifdata", 32'h0, rd)
        // enabled: input 1 sends its low status, the rest receive
        wr(OFF_MODE, 32'h10);
        wr(OFF_IFACE, 32'h4);
        wr(OFF_IFDATA, 32'hff);
        rdr(OFF_IFDATA); `CHK("ifdata", 32'hfd, rd)
        end_sim;
    end

    // hang guard
    initial begin
        wt(20000);
        fail_count++;
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
